//--- verilog/mft_pkg.sv
// constants for the multifunction totalizer / digital io block
package mft_pkg;
  // ----------------
  // register byte offsets
  // ----------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PORTA_IN = 8'h04;
  localparam logic [7:0] OFS_PORTB_IN = 8'h08;
  localparam logic [7:0] OFS_DOUT     = 8'h0c;
  localparam logic [7:0] OFS_PAT_A    = 8'h10;
  localparam logic [7:0] OFS_PAT_B    = 8'h14;
  localparam logic [7:0] OFS_TOT      = 8'h18;
  localparam logic [7:0] OFS_DAC0     = 8'h1c;
  localparam logic [7:0] OFS_DAC1     = 8'h20;
  localparam logic [7:0] OFS_SCAN     = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  // ----------------
  // control register fields
  // ----------------
  localparam int CTRL_FALL_EDGE = 0;
  localparam int CTRL_TOT_CLEAR = 1;
  localparam int CTRL_OE_A      = 2;
  localparam int CTRL_OE_B      = 3;
  localparam int CTRL_MODE_A    = 4;
  localparam int CTRL_MODE_B    = 5;
  localparam int CTRL_ALM_EN_A  = 6;
  localparam int CTRL_ALM_EN_B  = 7;
  localparam int CTRL_W         = 8;
  // pattern register: [7:0] pattern, [15:8] care mask
  localparam int PAT_VAL_LSB    = 0;
  localparam int PAT_CARE_LSB   = 8;
  // scan register: [0] scan strobe, [2:1] step select
  localparam int SCAN_GO        = 0;
  localparam int SCAN_SEL_LSB   = 1;
  // ----------------
  // status bits
  // ----------------
  localparam int IRQ_ALM_A      = 0;
  localparam int IRQ_ALM_B      = 1;
  localparam int IRQ_TOT_WRAP   = 2;
  localparam int IRQ_SCAN_DONE  = 3;
  localparam int IRQ_W          = 4;
  // ----------------
  // widths, limits, reset values
  // ----------------
  localparam int PORT_W         = 8;
  localparam int TOT_W          = 26;
  localparam int DAC_W          = 16;
  localparam logic [TOT_W-1:0] TOT_MAX = 26'h3ffffff;
  // setpoint in mV, signed: -12000..+12000
  localparam logic signed [DAC_W-1:0] DAC_MAX_MV = 16'sh2ee0;
  localparam logic signed [DAC_W-1:0] DAC_MIN_MV = -16'sh2ee0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [15:0] PAT_RST       = 16'h0000;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
  // ----------------
  // input timing
  // ----------------
  localparam int CLK_MHZ        = 250;
  localparam int TOT_RATE_KHZ   = 100;
  localparam int TOT_PERIOD_CYC = (CLK_MHZ * 1000) / TOT_RATE_KHZ;
  // scan step selectors
  typedef enum logic [1:0] {
    MFT_STEP_PORT_A,
    MFT_STEP_PORT_B,
    MFT_STEP_TOT,
    MFT_STEP_NONE
  } mft_step_t;
endpackage

//--- verilog/mft_top.sv
// multifunction totalizer, dual 8-bit digital io and dac setpoints
//
// Behaviour
// [R01] two independent 8-bit ports, each sampled as an input pattern
// [R02] live port values readable anytime and also captured by a scan step
// [R03] alarm on pattern match or on a configured pattern change
// [R04] pattern alarms run whether or not the port is scanned
// [R05] unconnected input bit reads one, grounded bit reads zero
// [R06] both ports drive one 16-bit output word as a single value
// [R07] 26-bit totalizer counting pulses up to 100 kHz
// [R08] count readable directly or captured by a scan step
// [R09] count on rising or falling input edge, by configuration
// [R10] count wraps from 67,108,863 to zero on next counted edge
// [R11] active-high gate enables counting when high, blocks when low
// [R12] active-low gate enables counting when low, blocks when high
// [R13] edge counts only when both gates enable at once
// [R14] unconnected gates default to enabling, giving continuous count
// [R15] two analog channels, each a 16-bit setpoint register
// [R16] setpoints span -12 V to +12 V in 1 mV steps
// [R17] pulse and gate inputs synchronised before edge detection
`timescale 1ns/1ns
module mft_top (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // digital ports, pulled up off-chip
  input  wire logic [7:0]  port_a_i,
  input  wire logic [7:0]  port_b_i,
  output logic [7:0]       port_a_o,
  output logic [7:0]       port_a_oe_o,
  output logic [7:0]       port_b_o,
  output logic [7:0]       port_b_oe_o,
  // totalizer
  input  wire logic        tot_in_i,
  input  wire logic        gate_hi_i,
  input  wire logic        gate_lo_n_i,
  // dac setpoints, signed millivolts
  output logic [15:0]      dac0_mv_o,
  output logic [15:0]      dac1_mv_o,
  output logic             irq_o
);

  // ----------------
  // input synchronisers
  // ----------------
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic [2:0] tin_s1_q, tin_s2_q;
  logic       tin_prev_q;

  // [R01] sample both ports
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pa_s1_q <= 8'hff;
      pa_s2_q <= 8'hff;
      pb_s1_q <= 8'hff;
      pb_s2_q <= 8'hff;
    end else begin
      pa_s1_q <= port_a_i;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_i;
      pb_s2_q <= pb_s1_q;
    end
  end

  // [R17] two-stage sync of pulse and gates
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tin_s1_q <= 3'h2;
      tin_s2_q <= 3'h2;
    end else begin
      tin_s1_q <= {gate_lo_n_i, gate_hi_i, tot_in_i};
      tin_s2_q <= tin_s1_q;
    end
  end

  // ----------------
  // registers
  // ----------------
  logic [mft_pkg::CTRL_W-1:0] ctrl_q;
  logic [15:0]                dout_q;
  logic [15:0]                pat_a_q, pat_b_q;
  logic [15:0]                dac0_q, dac1_q;
  logic [mft_pkg::TOT_W-1:0]  tot_q;
  logic [31:0]                scan_data_q;
  logic [mft_pkg::IRQ_W-1:0]  stat_q, mask_q;

  // ----------------
  // axi4-lite write side
  // ----------------
  logic       aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_fire;
  logic       wr_hit;
  logic [31:0] wr_val;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid_o;

  always_comb begin
    wr_hit = 1'b0;
    unique case (aw_addr_q)
      mft_pkg::OFS_CTRL, mft_pkg::OFS_DOUT, mft_pkg::OFS_PAT_A,
      mft_pkg::OFS_PAT_B, mft_pkg::OFS_DAC0, mft_pkg::OFS_DAC1,
      mft_pkg::OFS_SCAN, mft_pkg::OFS_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // byte-lane merge applied on top of zero for write-only strobes
  always_comb begin
    wr_val = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (w_strb_q[i]) begin
        wr_val[i*8 +: 8] = w_data_q[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_hold_q       <= 1'b0;
      w_hold_q        <= 1'b0;
      aw_addr_q       <= 8'h00;
      w_data_q        <= 32'h0000_0000;
      w_strb_q        <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= mft_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_q       <= 1'b1;
        aw_addr_q       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_q       <= 1'b1;
        w_data_q       <= s_axi_wdata_i;
        w_strb_q       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q      <= 1'b0;
        w_hold_q       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? mft_pkg::RESP_OKAY : mft_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // merged field update keeps unstrobed bytes
  function automatic logic [15:0] mrg16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    mrg16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // [R16] clamp setpoint to the +-12 V span
  function automatic logic [15:0] clamp_mv(input logic [15:0] v);
    if ($signed(v) > mft_pkg::DAC_MAX_MV) begin
      clamp_mv = mft_pkg::DAC_MAX_MV;
    end else if ($signed(v) < mft_pkg::DAC_MIN_MV) begin
      clamp_mv = mft_pkg::DAC_MIN_MV;
    end else begin
      clamp_mv = v;
    end
  endfunction

  logic tot_clr_p;
  logic scan_go_p;
  logic [1:0] scan_sel;
  assign tot_clr_p = wr_fire && aw_addr_q == mft_pkg::OFS_CTRL && w_strb_q[0]
                     && w_data_q[mft_pkg::CTRL_TOT_CLEAR];
  assign scan_go_p = wr_fire && aw_addr_q == mft_pkg::OFS_SCAN && w_strb_q[0]
                     && w_data_q[mft_pkg::SCAN_GO];
  assign scan_sel  = w_data_q[mft_pkg::SCAN_SEL_LSB +: 2];

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q  <= mft_pkg::CTRL_RST;
      dout_q  <= 16'hffff;
      pat_a_q <= mft_pkg::PAT_RST;
      pat_b_q <= mft_pkg::PAT_RST;
      dac0_q  <= 16'h0000;
      dac1_q  <= 16'h0000;
      mask_q  <= '0;
    end else if (wr_fire) begin
      unique case (aw_addr_q)
        mft_pkg::OFS_CTRL: begin
          // clear bit is a strobe, never stored
          if (w_strb_q[0]) begin
            ctrl_q <= wr_val[7:0] & ~(8'h01 << mft_pkg::CTRL_TOT_CLEAR);
          end
        end
        // [R06] one write sets the strobed bytes of the 16-bit word
        mft_pkg::OFS_DOUT:     dout_q  <= mrg16(dout_q, wr_val, w_strb_q);
        mft_pkg::OFS_PAT_A:    pat_a_q <= mrg16(pat_a_q, wr_val, w_strb_q);
        mft_pkg::OFS_PAT_B:    pat_b_q <= mrg16(pat_b_q, wr_val, w_strb_q);
        // [R15] two setpoint registers
        mft_pkg::OFS_DAC0:     dac0_q  <= clamp_mv(mrg16(dac0_q, wr_val, w_strb_q));
        mft_pkg::OFS_DAC1:     dac1_q  <= clamp_mv(mrg16(dac1_q, wr_val, w_strb_q));
        mft_pkg::OFS_IRQ_MASK: if (w_strb_q[0]) mask_q <= wr_val[mft_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------
  // digital output drive
  // ----------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_a_o    <= 8'hff;
      port_b_o    <= 8'hff;
      port_a_oe_o <= 8'h00;
      port_b_oe_o <= 8'h00;
      dac0_mv_o   <= 16'h0000;
      dac1_mv_o   <= 16'h0000;
    end else begin
      port_a_o    <= dout_q[7:0];
      port_b_o    <= dout_q[15:8];
      port_a_oe_o <= {8{ctrl_q[mft_pkg::CTRL_OE_A]}};
      port_b_oe_o <= {8{ctrl_q[mft_pkg::CTRL_OE_B]}};
      dac0_mv_o   <= dac0_q;
      dac1_mv_o   <= dac1_q;
    end
  end

  // ----------------
  // pattern alarms
  // ----------------
  logic [7:0] pa_prev_q, pb_prev_q;
  logic       alm_a, alm_b;

  // mode 0: match on cared bits; mode 1: any cared bit changed
  function automatic logic alarm(input logic [7:0] cur, input logic [7:0] prv,
                                 input logic [15:0] pat, input logic chg);
    logic [7:0] care;
    care = pat[mft_pkg::PAT_CARE_LSB +: 8];
    if (chg) begin
      alarm = |((cur ^ prv) & care);
    end else begin
      alarm = ((cur ^ pat[mft_pkg::PAT_VAL_LSB +: 8]) & care) == 8'h00;
    end
  endfunction

  // [R05] pull-ups make idle bits read one; reset state matches
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pa_prev_q <= 8'hff;
      pb_prev_q <= 8'hff;
    end else begin
      pa_prev_q <= pa_s2_q;
      pb_prev_q <= pb_s2_q;
    end
  end

  // [R03] match or change detection; [R04] independent of scan
  assign alm_a = ctrl_q[mft_pkg::CTRL_ALM_EN_A]
                 && alarm(pa_s2_q, pa_prev_q, pat_a_q, ctrl_q[mft_pkg::CTRL_MODE_A]);
  assign alm_b = ctrl_q[mft_pkg::CTRL_ALM_EN_B]
                 && alarm(pb_s2_q, pb_prev_q, pat_b_q, ctrl_q[mft_pkg::CTRL_MODE_B]);

  // ----------------
  // totalizer
  // ----------------
  logic edge_hit, gate_ok, tot_wrap;

  // [R09] edge select
  assign edge_hit = ctrl_q[mft_pkg::CTRL_FALL_EDGE] ? (tin_prev_q && !tin_s2_q[0])
                                                   : (!tin_prev_q && tin_s2_q[0]);
  // [R11] [R12] [R13] both gates must enable; [R14] pulls hold them enabling
  assign gate_ok  = tin_s2_q[1] && !tin_s2_q[2];
  assign tot_wrap = edge_hit && gate_ok && tot_q == mft_pkg::TOT_MAX;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tin_prev_q <= 1'b0;
    end else begin
      tin_prev_q <= tin_s2_q[0];
    end
  end

  // [R07] 26-bit count; [R10] wraps to zero past the maximum
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tot_q <= '0;
    end else if (tot_clr_p) begin
      tot_q <= '0;
    end else if (edge_hit && gate_ok) begin
      tot_q <= tot_wrap ? '0 : tot_q + 26'h1;
    end
  end

  // ----------------
  // scan step capture
  // ----------------
  // [R02] [R08] one scan step latches port or count
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_data_q <= 32'h0000_0000;
    end else if (scan_go_p) begin
      unique case (mft_pkg::mft_step_t'(scan_sel))
        mft_pkg::MFT_STEP_PORT_A: scan_data_q <= {24'h0, pa_s2_q};
        mft_pkg::MFT_STEP_PORT_B: scan_data_q <= {24'h0, pb_s2_q};
        mft_pkg::MFT_STEP_TOT:    scan_data_q <= {6'h0, tot_q};
        mft_pkg::MFT_STEP_NONE:   scan_data_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------
  // interrupt status, cleared by read, set wins
  // ----------------
  logic [mft_pkg::IRQ_W-1:0] ev;
  logic stat_rd;
  assign ev = {scan_go_p, tot_wrap, alm_b, alm_a};

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= (stat_rd ? '0 : stat_q) | ev;
      irq_o  <= |(((stat_rd ? '0 : stat_q) | ev) & mask_q);
    end
  end

  // ----------------
  // axi4-lite read side
  // ----------------
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      mft_pkg::OFS_CTRL:     rd_val = {24'h0, ctrl_q};
      // [R02] live port values
      mft_pkg::OFS_PORTA_IN: rd_val = {24'h0, pa_s2_q};
      mft_pkg::OFS_PORTB_IN: rd_val = {24'h0, pb_s2_q};
      mft_pkg::OFS_DOUT:     rd_val = {16'h0, dout_q};
      mft_pkg::OFS_PAT_A:    rd_val = {16'h0, pat_a_q};
      mft_pkg::OFS_PAT_B:    rd_val = {16'h0, pat_b_q};
      // [R08] manual read of the count
      mft_pkg::OFS_TOT:      rd_val = {6'h0, tot_q};
      mft_pkg::OFS_DAC0:     rd_val = {16'h0, dac0_q};
      mft_pkg::OFS_DAC1:     rd_val = {16'h0, dac1_q};
      mft_pkg::OFS_SCAN:     rd_val = scan_data_q;
      mft_pkg::OFS_IRQ_STAT: rd_val = {28'h0, stat_q};
      mft_pkg::OFS_IRQ_MASK: rd_val = {28'h0, mask_q};
      default:               rd_ok  = 1'b0;
    endcase
  end

  assign stat_rd = s_axi_arvalid_i && s_axi_arready_o
                   && s_axi_araddr_i == mft_pkg::OFS_IRQ_STAT;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= mft_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_val;
      s_axi_rresp_o   <= rd_ok ? mft_pkg::RESP_OKAY : mft_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

//--- test/mft_properties.sv
// bus and pin checker for the totalizer / digital io block
`timescale 1ns/1ns
module mft_properties (
  input wire logic        sys_clk_i,
  input wire logic        arst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [7:0]  port_a_oe_o,
  input wire logic [7:0]  port_b_oe_o,
  input wire logic [15:0] dac0_mv_o,
  input wire logic [15:0] dac1_mv_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_oe_a; port_a_oe_o == 8'h00 || port_a_oe_o == 8'hff; endproperty
  a_oe_a: assert property (p_oe_a) else $error("port a enable split");
  property p_oe_b; port_b_oe_o == 8'h00 || port_b_oe_o == 8'hff; endproperty
  a_oe_b: assert property (p_oe_b) else $error("port b enable split");
  property p_dac0; $signed(dac0_mv_o) <= mft_pkg::DAC_MAX_MV && $signed(dac0_mv_o) >= mft_pkg::DAC_MIN_MV; endproperty
  a_dac0: assert property (p_dac0) else $error("dac0 out of span");
  property p_dac1; $signed(dac1_mv_o) <= mft_pkg::DAC_MAX_MV && $signed(dac1_mv_o) >= mft_pkg::DAC_MIN_MV; endproperty
  a_dac1: assert property (p_dac1) else $error("dac1 out of span");
  // dac0 setpoint moves only by a write
  property p_dac_src; !$stable(dac0_mv_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o); endproperty
  a_dac_src: assert property (p_dac_src) else $error("dac0 moved without write");
  property p_rd_lat; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_busy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read accepted while busy");
  property p_wr_lat;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule

//--- test/mft_partner.sv
// contacts, pulse source and gate wiring at the block's pins
`timescale 1ns/1ns
module mft_partner (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] drv_a_i,
  input  wire logic [7:0] oe_a_i,
  input  wire logic [7:0] drv_b_i,
  input  wire logic [7:0] oe_b_i,
  input  wire logic [7:0] short_a_i,
  input  wire logic [7:0] short_b_i,
  input  wire logic       gh_conn_i,
  input  wire logic       gh_lvl_i,
  input  wire logic       gl_conn_i,
  input  wire logic       gl_lvl_i,
  output logic [7:0]      pin_a_o,
  output logic [7:0]      pin_b_o,
  output logic            tot_o,
  output logic            gate_hi_o,
  output logic            gate_lo_n_o
);
  localparam int HALF_CYC = mft_pkg::TOT_PERIOD_CYC / 2;
  assign pin_a_o = (oe_a_i & drv_a_i) | (~oe_a_i & ~short_a_i);
  assign pin_b_o = (oe_b_i & drv_b_i) | (~oe_b_i & ~short_b_i);
  assign gate_hi_o = gh_conn_i ? gh_lvl_i : 1'b1;
  assign gate_lo_n_o = gl_conn_i ? gl_lvl_i : 1'b0;
  initial tot_o = 1'b0;
  // never faster than the rated rate
  task automatic lvl(input logic v);
    tot_o <= v;
    repeat (HALF_CYC) @(posedge sys_clk_i);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask
endmodule

//--- test/mft_tb_top.sv
// self-checking bench for the totalizer / digital io block
`timescale 1ns/1ns
module mft_tb_top;
  typedef struct packed {
    logic [1:0]  r;
    logic [31:0] m;
    logic [31:0] d;
  } mft_exp_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tot, gh, gl;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pa, pb, oa, ob, oea, oeb;
  logic [7:0]  sa = 8'h00;
  logic [7:0]  sb = 8'h00;
  logic        ghc = 1'b0, ghl = 1'b0, glc = 1'b0, gll = 1'b0;
  logic [15:0] dac0, dac1, dout;
  logic [25:0] cnt = 26'h0;
  logic [15:0] dv [4] = '{16'h2ee0, 16'hffff, 16'h32c8, 16'hcd38};
  logic [15:0] de [4] = '{16'h2ee0, 16'hffff, 16'h2ee0, 16'hd120};
  logic [31:0] se [3];
  mft_exp_t    ex;
  mft_exp_t    rq [$];
  mft_exp_t    bq [$];
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  mft_top mft_top_inst (
    .sys_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_a_i(pa), .port_b_i(pb),
    .port_a_o(oa), .port_a_oe_o(oea), .port_b_o(ob), .port_b_oe_o(oeb), .tot_in_i(tot), .gate_hi_i(gh),
    .gate_lo_n_i(gl), .dac0_mv_o(dac0), .dac1_mv_o(dac1), .irq_o(irq));

  mft_partner mft_partner_inst (
    .sys_clk_i(clk), .drv_a_i(oa), .oe_a_i(oea), .drv_b_i(ob), .oe_b_i(oeb), .short_a_i(sa), .short_b_i(sb),
    .gh_conn_i(ghc), .gh_lvl_i(ghl), .gl_conn_i(glc), .gl_lvl_i(gll), .pin_a_o(pa), .pin_b_o(pb),
    .tot_o(tot), .gate_hi_o(gh), .gate_lo_n_o(gl));

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = mft_pkg::RESP_OKAY);
    bq.push_back('{r, 32'h0, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom);
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                    input logic [1:0] r = mft_pkg::RESP_OKAY);
    rq.push_back('{r, m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------
  // response monitor and hang guard
  // ----------------
  always @(posedge clk) begin
    if (rvalid && rready) begin
      ex = rq.pop_front();
      cmp("rresp", {30'h0, ex.r}, {30'h0, rresp});
      cmp("rdata", ex.d & ex.m, rdata & ex.m);
    end
    if (bvalid && bready) begin
      ex = bq.pop_front();
      cmp("bresp", {30'h0, ex.r}, {30'h0, bresp});
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(32'h5299));
    w(10);
    rst_n <= 1'b1;
    w(1);
    cmp("port_a_o", 32'hff, {24'h0, oa});
    cmp("oe", 32'h0, {16'h0, oea, oeb});
    cmp("irq", 32'h0, {31'h0, irq});
    rd(mft_pkg::OFS_CTRL, 32'h0);
    rd(mft_pkg::OFS_DOUT, 32'hffff);
    rd(mft_pkg::OFS_IRQ_STAT, 32'h0);
    rd(8'h3c, 32'h0, 32'hffffffff, mft_pkg::RESP_SLVERR);
    wr(mft_pkg::OFS_TOT, 32'h1, mft_pkg::RESP_SLVERR);
    wr(8'h30, 32'h1, mft_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      sa <= 8'($urandom);
      sb <= 8'($urandom);
      w(4);
      rd(mft_pkg::OFS_PORTA_IN, {24'h0, ~sa});
      rd(mft_pkg::OFS_PORTB_IN, {24'h0, ~sb});
    end
    dout = 16'($urandom);
    wr(mft_pkg::OFS_DOUT, {16'h0, dout});
    wr(mft_pkg::OFS_CTRL, 32'h0c);
    w(4);
    cmp("dout", {16'h0, dout}, {16'h0, ob, oa});
    cmp("oe", 32'hffff, {16'h0, oea, oeb});
    rd(mft_pkg::OFS_PORTB_IN, {24'h0, dout[15:8]});
    wstrb <= 4'h1;
    wr(mft_pkg::OFS_DOUT, 32'h0);
    wstrb <= 4'hf;
    rd(mft_pkg::OFS_DOUT, {16'h0, dout[15:8], 8'h00});
    wr(mft_pkg::OFS_CTRL, 32'h0);
    wr(mft_pkg::OFS_PAT_A, 32'hff5a);
    wr(mft_pkg::OFS_IRQ_MASK, 32'h0);
    wr(mft_pkg::OFS_CTRL, 32'h40);
    sa <= 8'ha5;
    w(6);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(mft_pkg::OFS_IRQ_MASK, 32'h1);
    w(3);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(mft_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    sa <= 8'h5a;
    w(4);
    rd(mft_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    rd(mft_pkg::OFS_IRQ_STAT, 32'h0, 32'h1);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(mft_pkg::OFS_PAT_B, 32'hff00);
    wr(mft_pkg::OFS_CTRL, 32'ha0);
    wr(mft_pkg::OFS_IRQ_MASK, 32'h2);
    w(4);
    rd(mft_pkg::OFS_IRQ_STAT, 32'h0);
    rd(mft_pkg::OFS_IRQ_STAT, 32'h0, 32'h2);
    sb <= sb ^ 8'h01;
    w(6);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(mft_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
    wr(mft_pkg::OFS_CTRL, 32'h02);
    rd(mft_pkg::OFS_TOT, 32'h0);
    mft_partner_inst.pulse(3);
    cnt = cnt + 26'd3;
    rd(mft_pkg::OFS_TOT, {6'h0, cnt});
    ghc <= 1'b1;
    mft_partner_inst.pulse(2);
    rd(mft_pkg::OFS_TOT, {6'h0, cnt});
    ghl <= 1'b1;
    glc <= 1'b1;
    gll <= 1'b1;
    mft_partner_inst.pulse(2);
    rd(mft_pkg::OFS_TOT, {6'h0, cnt});
    gll <= 1'b0;
    mft_partner_inst.pulse(2);
    cnt = cnt + 26'd2;
    rd(mft_pkg::OFS_TOT, {6'h0, cnt});
    mft_partner_inst.lvl(1'b1);
    wr(mft_pkg::OFS_CTRL, 32'h01);
    mft_partner_inst.pulse(1);
    cnt = cnt + 26'd2;
    rd(mft_pkg::OFS_TOT, {6'h0, cnt});
    se = '{{24'h0, ~sa}, {24'h0, ~sb}, {6'h0, cnt}};
    for (int i = 0; i < 3; i++) begin
      wr(mft_pkg::OFS_SCAN, 32'(i * 2 + 1));
      w(4);
      rd(mft_pkg::OFS_SCAN, se[i]);
    end
    rd(mft_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
    for (int i = 0; i < 4; i++) begin
      wr(i[0] ? mft_pkg::OFS_DAC1 : mft_pkg::OFS_DAC0, {16'h0, dv[i]});
      w(3);
      cmp("dac", {16'h0, de[i]}, {16'h0, i[0] ? dac1 : dac0});
    end
    rd(mft_pkg::OFS_DAC0, {16'h0, de[2]}, 32'hffff);
    final_report();
  end
endmodule

bind mft_top mft_properties mft_properties_inst (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .port_a_oe_o(port_a_oe_o),
  .port_b_oe_o(port_b_oe_o), .dac0_mv_o(dac0_mv_o), .dac1_mv_o(dac1_mv_o));
